/* File: pkg/uart_ctl_pkg.sv */
// How it works
// - DMA mode bit 1 requests transfers continuously until the receive FIFO empties.
// - Trigger bits 7:6 give receive levels 1, 4, 8 or 14 bytes.
// - Framing bits 1:0 select five to eight data bits, both directions.
// - Bit 2 set gives 1.5 stops for five bits, two otherwise.
// - Receiver checks only the first stop bit of every character.
// - Bit 3 inserts parity after data and enables the receive check.
// - Bit 4 set selects even parity, clear selects odd, without stick.
// - Stick parity sends and checks 0 when bit 4 set, 1 otherwise.
// - Bit 6 holds serial output low for a break.
// - Bit 7 steers shared addresses to divisor latches; software clears it first.
// - Modem bits 0 and 1 drive ready and request pins, inverted.
// - Modem bit 3 gates enabled interrupt sources onto the interrupt output.
// - Loopback holds serial output high, ignores input, loops transmit to receive.
// - Loopback ignores modem inputs, feeds them from outputs, forces pins high.
// - Loopback keeps interrupts working; modem status comes from modem control bits.
// - Modem bit 5 enables flow control; with bit 1 automatic request too.
// - Automatic request goes high at trigger level, low again once emptied.
// - Automatic clear-to-send lets a character start only while input is low.
// - Line framing register reads back what software wrote.
// - DMA mode bit 0 requests single transfers only.
`default_nettype none
package uart_ctl_pkg;
    localparam int ADDR_W = 5;
    localparam int LEVEL_W = 5;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_FIFO_SETUP = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_LINE_FRAMING = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_MODEM_CTRL = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_INT_ENABLES = 5'h0C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h10;
    localparam logic [7:0] RESET_REG = 8'h00;
    localparam logic [3:0] RESET_IER = 4'h0;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FS_ENABLE = 0;
    localparam int FS_RX_CLEAR = 1;
    localparam int FS_TX_CLEAR = 2;
    localparam int FS_DMA_MODE = 3;
    localparam int FS_TRIG_LO = 6;
    localparam int LF_STOP = 2;
    localparam int LF_PAR_EN = 3;
    localparam int LF_EVEN = 4;
    localparam int LF_STICK = 5;
    localparam int LF_BREAK = 6;
    localparam int LF_DIV_ACCESS = 7;
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_OUT1 = 2;
    localparam int MC_OUT2 = 3;
    localparam int MC_LOOP = 4;
    localparam int MC_FLOW = 5;
    // ------------------------------------------------------------
    // Trigger levels, framing counts, responses
    // ------------------------------------------------------------
    localparam logic [LEVEL_W-1:0] TRIG_L0 = 5'h01;
    localparam logic [LEVEL_W-1:0] TRIG_L1 = 5'h04;
    localparam logic [LEVEL_W-1:0] TRIG_L2 = 5'h08;
    localparam logic [LEVEL_W-1:0] TRIG_L3 = 5'h0E;
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;
    localparam logic [2:0] STOP_HALVES_ONE = 3'h2;
    localparam logic [2:0] STOP_HALVES_ONE_HALF = 3'h3;
    localparam logic [2:0] STOP_HALVES_TWO = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: hdl/uart_line_modem_control.sv */
// The implementer's own choices: register access over AXI4-Lite and the address map.
`default_nettype none
module uart_line_modem_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [uart_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [uart_ctl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_in,
    output logic serial_out,
    input wire logic tx_shift_out,
    output logic rx_shift_in,
    input wire logic [7:0] tx_char,
    output logic tx_parity_bit,
    input wire logic [7:0] rx_char,
    input wire logic rx_parity_in,
    input wire logic rx_first_stop,
    output logic rx_parity_error,
    output logic rx_framing_error,
    output logic [3:0] data_bits,
    output logic [2:0] tx_stop_halves,
    output logic parity_enable,
    output logic divisor_access,
    input wire logic [uart_ctl_pkg::LEVEL_W-1:0] rx_fifo_level,
    output logic [uart_ctl_pkg::LEVEL_W-1:0] rx_trigger_level,
    output logic fifo_enable,
    output logic rx_fifo_clear,
    output logic tx_fifo_clear,
    output logic dma_multi,
    output logic rx_dma_req,
    input wire logic clear_to_send_n,
    input wire logic data_set_ready_n,
    input wire logic carrier_detect_n,
    input wire logic ring_indicator_n,
    output logic terminal_ready_out_n,
    output logic request_to_send_n,
    output logic user_output_one_n,
    output logic user_output_two_n,
    output logic [3:0] modem_status,
    output logic tx_start_allow,
    input wire logic [3:0] int_sources,
    output logic int_out
);
    import uart_ctl_pkg::*;

    logic [7:0] fifo_setup_reg;
    logic [7:0] line_framing_reg;
    logic [7:0] modem_lines_control_reg;
    logic [3:0] interrupt_enables_reg;
    logic aw_have_reg;
    logic w_have_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [7:0] w_byte_reg;
    logic w_lane_reg;
    logic rts_hold_reg;
    logic dma_active_reg;
    logic do_write;
    logic wr_fifo;
    logic wr_lf;
    logic wr_mc;
    logic wr_ie;
    logic wr_known;
    logic loop_on;
    logic auto_rts;
    logic cts_asserted;
    logic [LEVEL_W-1:0] trig_next;
    logic [7:0] rd_value;
    logic rd_known;

    // ------------------------------------------------------------
    // Framing helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] char_mask(input logic [1:0] wl);
        case (wl)
            2'h0: char_mask = 8'h1F;
            2'h1: char_mask = 8'h3F;
            2'h2: char_mask = 8'h7F;
            default: char_mask = 8'hFF;
        endcase
    endfunction

    function automatic logic parity_of(input logic [7:0] lf, input logic [7:0] ch);
        logic ones;
        ones = ^(ch & char_mask(lf[1:0]));
        if (lf[LF_STICK]) begin
            parity_of = ~lf[LF_EVEN];
        end else if (lf[LF_EVEN]) begin
            parity_of = ones;
        end else begin
            parity_of = ~ones;
        end
    endfunction

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    // Address and data are taken in either order; one write in flight.
    assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_known = (aw_addr_reg == ADDR_FIFO_SETUP) || (aw_addr_reg == ADDR_LINE_FRAMING)
        || (aw_addr_reg == ADDR_MODEM_CTRL) || (aw_addr_reg == ADDR_INT_ENABLES)
        || (aw_addr_reg == ADDR_STATUS);
    assign wr_fifo = do_write && w_lane_reg && (aw_addr_reg == ADDR_FIFO_SETUP);
    assign wr_lf = do_write && w_lane_reg && (aw_addr_reg == ADDR_LINE_FRAMING);
    assign wr_mc = do_write && w_lane_reg && (aw_addr_reg == ADDR_MODEM_CTRL);
    assign wr_ie = do_write && w_lane_reg && (aw_addr_reg == ADDR_INT_ENABLES);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_have_reg <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            w_have_reg <= 1'b0;
            w_byte_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_byte_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_have_reg <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fifo_setup_reg <= RESET_REG;
            rx_fifo_clear <= 1'b0;
            tx_fifo_clear <= 1'b0;
        end else begin
            rx_fifo_clear <= wr_fifo && w_byte_reg[FS_ENABLE] && w_byte_reg[FS_RX_CLEAR];
            tx_fifo_clear <= wr_fifo && w_byte_reg[FS_ENABLE] && w_byte_reg[FS_TX_CLEAR];
            if (wr_fifo) begin
                fifo_setup_reg[FS_ENABLE] <= w_byte_reg[FS_ENABLE];
                if (w_byte_reg[FS_ENABLE]) begin
                    fifo_setup_reg[7:1] <= w_byte_reg[7:1];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            line_framing_reg <= RESET_REG;
        end else if (wr_lf) begin
            line_framing_reg <= w_byte_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            modem_lines_control_reg <= RESET_REG;
            interrupt_enables_reg <= RESET_IER;
        end else begin
            if (wr_mc) begin
                modem_lines_control_reg <= w_byte_reg;
            end
            if (wr_ie) begin
                interrupt_enables_reg <= w_byte_reg[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_comb begin
        rd_value = 8'h00;
        rd_known = 1'b1;
        case (s_axi_araddr)
            ADDR_FIFO_SETUP: rd_value = 8'h00;
            ADDR_LINE_FRAMING: rd_value = line_framing_reg;
            ADDR_MODEM_CTRL: rd_value = modem_lines_control_reg;
            ADDR_INT_ENABLES: rd_value = {4'h0, interrupt_enables_reg};
            ADDR_STATUS: rd_value = {rx_dma_req, tx_start_allow, rts_hold_reg, 1'b0,
                modem_status};
            default: rd_known = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_value};
            s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Framing and FIFO setup outputs
    // ------------------------------------------------------------
    always_comb begin
        case (fifo_setup_reg[7:FS_TRIG_LO])
            2'h0: trig_next = TRIG_L0;
            2'h1: trig_next = TRIG_L1;
            2'h2: trig_next = TRIG_L2;
            default: trig_next = TRIG_L3;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_bits <= MIN_DATA_BITS;
            tx_stop_halves <= STOP_HALVES_ONE;
            parity_enable <= 1'b0;
            divisor_access <= 1'b0;
            rx_trigger_level <= TRIG_L0;
            fifo_enable <= 1'b0;
            dma_multi <= 1'b0;
        end else begin
            data_bits <= MIN_DATA_BITS + {2'h0, line_framing_reg[1:0]};
            if (!line_framing_reg[LF_STOP]) begin
                tx_stop_halves <= STOP_HALVES_ONE;
            end else if (line_framing_reg[1:0] == 2'h0) begin
                tx_stop_halves <= STOP_HALVES_ONE_HALF;
            end else begin
                tx_stop_halves <= STOP_HALVES_TWO;
            end
            parity_enable <= line_framing_reg[LF_PAR_EN];
            divisor_access <= line_framing_reg[LF_DIV_ACCESS];
            rx_trigger_level <= trig_next;
            fifo_enable <= fifo_setup_reg[FS_ENABLE];
            dma_multi <= fifo_setup_reg[FS_DMA_MODE];
        end
    end

    // Parity is computed over the masked character so unused bits never leak in
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_parity_bit <= 1'b0;
            rx_parity_error <= 1'b0;
            rx_framing_error <= 1'b0;
        end else begin
            tx_parity_bit <= parity_of(line_framing_reg, tx_char);
            rx_parity_error <= line_framing_reg[LF_PAR_EN]
                && (rx_parity_in != parity_of(line_framing_reg, rx_char));
            rx_framing_error <= !rx_first_stop;
        end
    end

    // ------------------------------------------------------------
    // DMA request
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dma_active_reg <= 1'b0;
            rx_dma_req <= 1'b0;
        end else if (fifo_setup_reg[FS_DMA_MODE]) begin
            if (rx_fifo_level >= trig_next) begin
                dma_active_reg <= 1'b1;
            end else if (rx_fifo_level == '0) begin
                dma_active_reg <= 1'b0;
            end
            rx_dma_req <= (dma_active_reg || rx_fifo_level >= trig_next)
                && rx_fifo_level != '0;
        end else begin
            dma_active_reg <= 1'b0;
            rx_dma_req <= rx_fifo_level != '0;
        end
    end

    // ------------------------------------------------------------
    // Serial path, modem lines, flow control
    // ------------------------------------------------------------
    assign loop_on = modem_lines_control_reg[MC_LOOP];
    assign auto_rts = modem_lines_control_reg[MC_FLOW] && modem_lines_control_reg[MC_RTS];
    // Loopback takes clear-to-send from the request bit itself
    assign cts_asserted = loop_on ? modem_lines_control_reg[MC_RTS] : !clear_to_send_n;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serial_out <= 1'b1;
            rx_shift_in <= 1'b1;
        end else begin
            if (loop_on) begin
                serial_out <= 1'b1;
                rx_shift_in <= tx_shift_out && !line_framing_reg[LF_BREAK];
            end else begin
                serial_out <= tx_shift_out && !line_framing_reg[LF_BREAK];
                rx_shift_in <= serial_in;
            end
        end
    end

    // While automatic request is on, hold state flips only at trigger and at empty to avoid chatter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rts_hold_reg <= 1'b0;
        end else if (!auto_rts) begin
            rts_hold_reg <= 1'b0;
        end else if (rx_fifo_level >= trig_next) begin
            rts_hold_reg <= 1'b1;
        end else if (rx_fifo_level == '0) begin
            rts_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            terminal_ready_out_n <= 1'b1;
            request_to_send_n <= 1'b1;
            user_output_one_n <= 1'b1;
            user_output_two_n <= 1'b1;
        end else if (loop_on) begin
            terminal_ready_out_n <= 1'b1;
            request_to_send_n <= 1'b1;
            user_output_one_n <= 1'b1;
            user_output_two_n <= 1'b1;
        end else begin
            terminal_ready_out_n <= !modem_lines_control_reg[MC_DTR];
            request_to_send_n <= auto_rts ? rts_hold_reg
                : !modem_lines_control_reg[MC_RTS];
            user_output_one_n <= !modem_lines_control_reg[MC_OUT1];
            user_output_two_n <= !modem_lines_control_reg[MC_OUT2];
        end
    end

    // Status order: carrier, ring, data set ready, clear to send
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            modem_status <= 4'h0;
            tx_start_allow <= 1'b1;
            int_out <= 1'b0;
        end else begin
            if (loop_on) begin
                modem_status <= {modem_lines_control_reg[MC_OUT2],
                    modem_lines_control_reg[MC_OUT1], modem_lines_control_reg[MC_DTR],
                    modem_lines_control_reg[MC_RTS]};
            end else begin
                modem_status <= ~{carrier_detect_n, ring_indicator_n, data_set_ready_n,
                    clear_to_send_n};
            end
            // Remote must lift the line before mid stop bit to stop the next start
            tx_start_allow <= !modem_lines_control_reg[MC_FLOW] || cts_asserted;
            int_out <= modem_lines_control_reg[MC_OUT2]
                && |(interrupt_enables_reg & int_sources);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_break_holds_low: assert property (@(posedge clk) disable iff (!rst_n)
        line_framing_reg[LF_BREAK] && !loop_on |=> !serial_out)
        else $error("break did not hold serial output low");
    a_loop_pins_high: assert property (@(posedge clk) disable iff (!rst_n)
        loop_on |=> serial_out && request_to_send_n && terminal_ready_out_n
            && user_output_one_n && user_output_two_n)
        else $error("loopback left a pin low");
    a_dtr_pin_inverts: assert property (@(posedge clk) disable iff (!rst_n)
        !loop_on |=> terminal_ready_out_n == !$past(modem_lines_control_reg[MC_DTR]))
        else $error("ready pin not inverse of its bit");
    a_irq_gated_off: assert property (@(posedge clk) disable iff (!rst_n)
        !modem_lines_control_reg[MC_OUT2] |=> !int_out)
        else $error("interrupt passed a closed gate");
    a_cts_holds_tx: assert property (@(posedge clk) disable iff (!rst_n)
        modem_lines_control_reg[MC_FLOW] && !loop_on && clear_to_send_n |=> !tx_start_allow)
        else $error("start allowed while clear-to-send high");
    a_rts_at_trigger: assert property (@(posedge clk) disable iff (!rst_n)
        auto_rts && rx_fifo_level >= trig_next |=> rts_hold_reg)
        else $error("automatic request not dropped at trigger");
    a_fifo_bits_guard: assert property (@(posedge clk) disable iff (!rst_n)
        wr_fifo && !w_byte_reg[FS_ENABLE] |=> $stable(fifo_setup_reg[7:1]))
        else $error("setup bits changed without enable");
    a_stop_one_half: assert property (@(posedge clk) disable iff (!rst_n)
        line_framing_reg[LF_STOP] && line_framing_reg[1:0] == 2'h0
        |=> tx_stop_halves == STOP_HALVES_ONE_HALF)
        else $error("wrong stop length for five bits");
    a_stick_parity: assert property (@(posedge clk) disable iff (!rst_n)
        line_framing_reg[LF_STICK] |=> tx_parity_bit == !$past(line_framing_reg[LF_EVEN]))
        else $error("stick parity value wrong");
    a_reset_clears: assert property (@(posedge clk)
        !rst_n |=> line_framing_reg == RESET_REG && modem_lines_control_reg == RESET_REG)
        else $error("control registers not zero after reset");
endmodule
`default_nettype wire

/* File: tb/modem_partner.sv */
`default_nettype none
module modem_partner (
    input wire logic clk,
    input wire logic hold_off,
    output logic clear_to_send_n,
    output logic data_set_ready_n,
    output logic carrier_detect_n,
    output logic ring_indicator_n,
    output logic serial_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Raised a clock after the request, well ahead of any stop bit
    always @(posedge clk) begin
        clear_to_send_n <= hold_off;
    end
    assign serial_in = 1'b1;
    assign data_set_ready_n = 1'b0;
    assign carrier_detect_n = 1'b0;
    assign ring_indicator_n = 1'b1;
endmodule
`default_nettype wire

/* File: tb/uart_line_modem_control_bench.sv */
`default_nettype none
module uart_line_modem_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import uart_ctl_pkg::*;
    logic clk, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_shift_out = 1'b1, hold_off = 1'b0;
    logic rx_parity_in = 1'b0, rx_first_stop = 1'b1;
    logic [ADDR_W-1:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF, int_sources = 4'h0, data_bits, modem_status;
    logic [7:0] tx_char = 8'h07, rx_char = 8'h07;
    logic [4:0] rx_fifo_level = 5'h00, rx_trigger_level;
    logic [2:0] tx_stop_halves;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_in;
    logic serial_out, rx_shift_in, tx_parity_bit, rx_parity_error, rx_framing_error;
    logic parity_enable, divisor_access, fifo_enable, rx_fifo_clear, tx_fifo_clear, dma_multi;
    logic rx_dma_req, clear_to_send_n, data_set_ready_n, carrier_detect_n, ring_indicator_n;
    logic terminal_ready_out_n, request_to_send_n, user_output_one_n, user_output_two_n;
    logic tx_start_allow, int_out;
    int fail_count = 0;
    int checks_done = 0;
    int clears = 0;
    int trig[4] = '{1, 4, 8, 14};
    logic [7:0] par_mode[4] = '{8'h08, 8'h18, 8'h28, 8'h38};
    logic [3:0] par_exp = 4'b0110;
    uart_line_modem_control u_uart_line_modem_control (.*);
    modem_partner u_modem_partner (.*);
    // Counts clear pulses; held off during reset so an unknown never sticks
    always @(posedge clk) begin
        if (rst_n) begin
            clears <= clears + 32'(rx_fifo_clear) + 32'(tx_fifo_clear);
        end
    end
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Settles three edges after the answer, covering the output lag
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic rdr(input logic [ADDR_W-1:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Whole run is a few hundred cycles; this is far beyond it
    initial begin
        #400000;
        fail_count++;
        finish_test();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdr(ADDR_MODEM_CTRL);
        chk(rd, 32'h0);
        chk({terminal_ready_out_n, request_to_send_n, serial_out, data_bits}, 32'h75);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_LINE_FRAMING, 8'h04 | 8'(i));
            chk(data_bits, 32'(i + 5));
            chk(tx_stop_halves, (i == 0) ? 32'h3 : 32'h4);
            rdr(ADDR_LINE_FRAMING);
            chk(rd, 32'(i + 4));
            wr(ADDR_FIFO_SETUP, {2'(i), 6'h09});
            chk(rx_trigger_level, trig[i]);
            chk({fifo_enable, dma_multi}, 32'h3);
            wr(ADDR_LINE_FRAMING, par_mode[i]);
            chk(tx_parity_bit, par_exp[i]);
            chk({parity_enable, rx_parity_error}, {31'h1, par_exp[i]});
        end
        wr(ADDR_FIFO_SETUP, 8'h01);
        chk({fifo_enable, dma_multi}, 32'h2);
        wr(ADDR_FIFO_SETUP, 8'hCE);
        chk({fifo_enable, dma_multi, rx_trigger_level}, 32'h01);
        rx_fifo_level <= 5'h01;
        wr(ADDR_FIFO_SETUP, 8'h07);
        chk(clears, 32'd2);
        chk(rx_dma_req, 32'h1);
        wr(ADDR_FIFO_SETUP, 8'h49);
        chk(rx_dma_req, 32'h0);
        rx_fifo_level <= 5'h04;
        repeat (3) @(posedge clk);
        rx_fifo_level <= 5'h02;
        repeat (3) @(posedge clk);
        chk(rx_dma_req, 32'h1);
        rx_fifo_level <= 5'h00;
        repeat (3) @(posedge clk);
        chk(rx_dma_req, 32'h0);
        $display("framing test done");
        rx_first_stop <= 1'b0;
        wr(ADDR_LINE_FRAMING, 8'h47);
        chk({serial_out, rx_framing_error}, 32'h1);
        wr(ADDR_MODEM_CTRL, 8'h03);
        chk({terminal_ready_out_n, request_to_send_n}, 32'h0);
        int_sources <= 4'h1;
        wr(ADDR_INT_ENABLES, 8'h01);
        chk(int_out, 32'h0);
        wr(ADDR_MODEM_CTRL, 8'h08);
        chk(int_out, 32'h1);
        chk({user_output_one_n, user_output_two_n}, 32'h2);
        chk({rx_shift_in, modem_status}, 32'h1B);
        $display("line test done");
        tx_shift_out <= 1'b0;
        wr(ADDR_LINE_FRAMING, 8'h00);
        wr(ADDR_MODEM_CTRL, 8'h1F);
        chk({serial_out, rx_shift_in}, 32'h2);
        chk({terminal_ready_out_n, request_to_send_n, modem_status}, 32'h3F);
        chk({user_output_one_n, user_output_two_n}, 32'h3);
        wr(ADDR_MODEM_CTRL, 8'h22);
        chk(request_to_send_n, 32'h0);
        rx_fifo_level <= 5'h04;
        hold_off <= 1'b1;
        repeat (4) @(posedge clk);
        chk({request_to_send_n, tx_start_allow}, 32'h2);
        rx_fifo_level <= 5'h00;
        hold_off <= 1'b0;
        repeat (4) @(posedge clk);
        chk({request_to_send_n, tx_start_allow}, 32'h1);
        rdr(5'h14);
        chk(resp, 32'h2);
        wr(ADDR_LINE_FRAMING, 8'h80);
        chk({divisor_access, resp}, 32'h4);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdr(ADDR_LINE_FRAMING);
        chk(rd, 32'h0);
        rdr(ADDR_MODEM_CTRL);
        chk(rd, 32'h0);
        $display("modem test done");
        finish_test();
    end
endmodule
`default_nettype wire
